// *** src/low_power_mode_controller.sv ***
`timescale 1ns/10ps
// Summary of operation
// [R01] Sleep instruction with standby select 0 halts CPU only; peripherals run.
// [R02] Transfer controller and trace debugger make no data accesses in sleep.
// [R03] Power-on reset from pin or watchdog ends sleep; release starts reset.
// [R04] Manual reset pin low with power-on pin high, or watchdog, ends sleep.
// [R05] Hardware standby pin low enters hardware standby from every mode.
// [R06] Sleep with standby select 1 stops CPU, peripherals and oscillator.
// [R07] Port float select chooses held or high impedance pins in software standby.
// [R08] Selected nmi edge restarts oscillator, clocking only the watchdog.
// [R09] After watchdog overflow, clock whole chip, leave standby, start exception.
// [R10] Software sets watchdog clock select longer than oscillator settling.
// [R11] Nmi pin level at entry opposes wake edge level at restart.
// [R12] Power-on reset pin low in software standby restarts clock chip-wide.
// [R13] Irq edge wakes only with irq wake enable set; watchdog-timed exit.
// [R14] Software sets wake irq priority above CPU interrupt mask.
// [R15] Falling or both sensing wakes on fall, rising on rise; no level.
// [R16] Irq pin level at entry opposes wake edge level at restart.
// [R17] Hardware standby holds every function in reset and stopped.
// [R18] Software clears ram enable first; boot mode pins stay unchanged.
// [R19] Standby pin rising with reset low enters reset, starts oscillator.
// [R20] Module stop bit applies or clears at end of current bus cycle.
// [R21] Serial, timer and converter modules sit in module standby after reset.
// [R22] Register access blocked to a module in module standby.
// [R23] Only the CPU writes the module stop control bits.
// [R24] Software disables a module's interrupts before stopping it.
// [R25] State machine; hardware standby pin outranks all other conditions.
module low_power_mode_controller
    import lpm_pkg::*;
#(
    parameter int WAIT_BASE = WDT_BASE_CYCLES,
    parameter int NMOD      = MSTOP_COUNT
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    // External pins, asynchronous
    input  wire logic                   i_power_on_reset_pin_n,
    input  wire logic                   i_manual_reset_pin_n,
    input  wire logic                   i_hw_standby_pin_n,
    input  wire logic                   i_nmi_pin,
    input  wire logic [IRQ_COUNT-1:0]   i_irq_pin_n,
    // CPU and watchdog events
    input  wire logic                   i_sleep_exec,
    input  wire logic                   i_wdt_por,
    input  wire logic                   i_wdt_manual_reset_pin,
    // Configuration bits
    input  wire logic                   i_standby_select,
    input  wire logic                   i_port_float_select,
    input  wire logic                   i_nmi_edge_select,
    input  wire logic                   i_irq_wake_enable,
    input  wire logic [IRQ_COUNT-1:0]   i_irq_sense_select,
    input  wire logic [2*IRQ_COUNT-1:0] i_irq_edge_select,
    input  wire logic [2:0]             i_watchdog_clock_select,
    // Module stop control
    input  wire logic                   i_module_stop_wr,
    input  wire logic [NMOD-1:0]        i_module_stop_wdata,
    input  wire logic                   i_bus_cycle_end,
    input  wire logic [NMOD-1:0]        i_module_access_req,
    // Mode outputs
    output logic [2:0]                  o_mode,
    output logic                        o_cpu_halt,
    output logic                        o_periph_stop,
    output logic                        o_osc_enable,
    output logic                        o_wdt_clock_only,
    output logic                        o_chip_clock_en,
    output logic                        o_port_hiz,
    output logic                        o_chip_reset,
    output logic                        o_por_reset,
    output logic                        o_manual_reset,
    output logic                        o_sleep_dma_block,
    // Exception requests
    output logic                        o_nmi_exception,
    output logic                        o_irq_exception,
    output logic [IRQ_COUNT-1:0]        o_irq_wake_source,
    // Module standby
    output logic [NMOD-1:0]             o_module_stop,
    output logic [NMOD-1:0]             o_module_access_grant
);

    localparam int NPIN = 4 + IRQ_COUNT;

    lpm_state_type          state_q;
    lpm_state_type          state_d;
    logic [NPIN-1:0]        pin_meta_q;
    logic [NPIN-1:0]        pin_sync_q;
    logic [NPIN-1:0]        pin_prev_q;
    logic [2:0]             cks_q;
    logic                   hiz_sel_q;
    logic                   wake_nmi_q;
    logic [IRQ_COUNT-1:0]   wake_irq_q;
    logic [WAIT_CNT_W-1:0]  wait_cnt_q;
    logic [WAIT_CNT_W-1:0]  wait_target;
    logic                   wait_done;
    logic                   por_pin_n;
    logic                   manual_reset_pin_pin_n;
    logic                   hw_standby_pin_pin_n;
    logic                   nmi_now;
    logic                   nmi_before;
    logic [IRQ_COUNT-1:0]   irq_now_n;
    logic [IRQ_COUNT-1:0]   irq_before_n;
    logic                   por_active;
    logic                   manual_reset_pin_active;
    logic                   nmi_wake;
    logic [IRQ_COUNT-1:0]   irq_fall;
    logic [IRQ_COUNT-1:0]   irq_rise;
    logic [IRQ_COUNT-1:0]   irq_wake;
    logic                   in_sw_stby;
    logic                   enter_wait;
    logic                   leave_wait;

    // Two-stage synchronisers; the second stage and a third, previous-value stage for edge detection feed logic
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_meta_q <= {{(NPIN-1){1'h1}}, 1'h0}; // Power-on pin reads asserted until the real level arrives
            pin_sync_q <= {{(NPIN-1){1'h1}}, 1'h0};
            pin_prev_q <= {NPIN{1'h1}};
        end
        else
        begin
            pin_meta_q <= {i_irq_pin_n, i_nmi_pin, i_hw_standby_pin_n,
                           i_manual_reset_pin_n, i_power_on_reset_pin_n};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Named views of the synchronised pins
    assign por_pin_n    = pin_sync_q[0];
    assign manual_reset_pin_pin_n   = pin_sync_q[1];
    assign hw_standby_pin_pin_n  = pin_sync_q[2];
    assign nmi_now      = pin_sync_q[3];
    assign nmi_before   = pin_prev_q[3];
    assign irq_now_n    = pin_sync_q[NPIN-1:4];
    assign irq_before_n = pin_prev_q[NPIN-1:4];

    // Reset causes; manual reset pin counts only while power-on pin is high, watchdog manual reset always
    assign por_active  = ~por_pin_n | i_wdt_por;                     // [R03]
    assign manual_reset_pin_active = (por_pin_n & ~manual_reset_pin_pin_n) | i_wdt_manual_reset_pin;      // [R04]

    // Nmi wake edge follows the nmi edge select bit
    assign nmi_wake = (i_nmi_edge_select == NMI_EDGE_RISE) ? (nmi_now & ~nmi_before)
                                                          : (~nmi_now & nmi_before); // [R08]

    // Irq wake: edge sensing only, both-edge setting starts on the fall
    assign irq_fall = ~irq_now_n & irq_before_n;
    assign irq_rise = irq_now_n & ~irq_before_n;
    genvar g;
    generate
        for (g = 0; g < IRQ_COUNT; g++)
        begin : g_irq
            logic [1:0] esel;
            assign esel = i_irq_edge_select[2*g+1:2*g];
            assign irq_wake[g] = i_irq_wake_enable
                               & (i_irq_sense_select[g] == IRQ_SENSE_EDGE)
                               & ((((esel == IRQ_EDGE_FALL) | (esel == IRQ_EDGE_BOTH)) & irq_fall[g])
                                 | ((esel == IRQ_EDGE_RISE) & irq_rise[g])); // [R13] [R15]
        end
    endgenerate

    // Stabilisation wait scales with the clock select caught at entry
    assign wait_target = WAIT_CNT_W'(WAIT_BASE) << cks_q;             // [R09]
    assign wait_done   = (wait_cnt_q == wait_target - WAIT_CNT_W'(1));

    // Next mode; hardware standby pin is checked before anything else
    always_comb
    begin
        state_d = state_q;
        if (!hw_standby_pin_pin_n)
        begin
            state_d = ST_HW_STBY;                                     // [R05] [R25]
        end
        else
        begin
            case (state_q)
                ST_RUN:
                begin
                    if (por_active || manual_reset_pin_active)
                        state_d = ST_RESET;
                    else if (i_sleep_exec)
                        state_d = i_standby_select ? ST_SW_STBY : ST_SLEEP; // [R01] [R06]
                end
                ST_SLEEP:
                begin
                    if (por_active || manual_reset_pin_active)
                        state_d = ST_RESET;                           // [R03] [R04]
                end
                ST_SW_STBY:
                begin
                    if (por_active)
                        state_d = ST_RESET;                           // [R12]
                    else if (nmi_wake || (|irq_wake))
                        state_d = ST_OSC_WAIT;                        // [R08] [R13]
                end
                ST_OSC_WAIT:
                begin
                    if (por_active)
                        state_d = ST_RESET;
                    else if (wait_done)
                        state_d = ST_RUN;                             // [R09]
                end
                ST_HW_STBY:
                begin
                    state_d = ST_RESET;                               // [R19]
                end
                ST_RESET:
                begin
                    if (!por_active && !manual_reset_pin_active)
                        state_d = ST_RUN;
                end
                default:
                begin
                    state_d = ST_RESET;
                end
            endcase
        end
    end

    assign in_sw_stby = (state_q == ST_SW_STBY);
    assign enter_wait = in_sw_stby && (state_d == ST_OSC_WAIT);
    assign leave_wait = (state_q == ST_OSC_WAIT) && (state_d == ST_RUN);

    // Mode register and settings caught at standby entry
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q    <= ST_RESET;
            cks_q      <= 3'h0;
            hiz_sel_q  <= 1'h0;
            wake_nmi_q <= 1'h0;
            wake_irq_q <= {IRQ_COUNT{1'h0}};
        end
        else
        begin
            state_q <= state_d;
            if (state_q == ST_RUN && state_d == ST_SW_STBY)
            begin
                cks_q     <= i_watchdog_clock_select;                 // [R09]
                hiz_sel_q <= i_port_float_select;                     // [R07]
            end
            if (enter_wait)
            begin
                wake_nmi_q <= nmi_wake;
                wake_irq_q <= nmi_wake ? {IRQ_COUNT{1'h0}} : irq_wake;
            end
        end
    end

    // Watchdog overflow counter runs only while waiting
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            wait_cnt_q <= {WAIT_CNT_W{1'h0}};
        else if (state_q == ST_OSC_WAIT)
            wait_cnt_q <= wait_cnt_q + WAIT_CNT_W'(1);
        else
            wait_cnt_q <= {WAIT_CNT_W{1'h0}};
    end

    // Registered mode outputs, decoded from the next mode so they track it
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_mode            <= ST_RESET;
            o_cpu_halt        <= 1'h1;
            o_periph_stop     <= 1'h0;
            o_osc_enable      <= 1'h1;
            o_wdt_clock_only  <= 1'h0;
            o_chip_clock_en   <= 1'h1;
            o_port_hiz        <= 1'h0;
            o_chip_reset      <= 1'h0;
            o_por_reset       <= 1'h1;
            o_manual_reset    <= 1'h0;
            o_sleep_dma_block <= 1'h0;
            o_nmi_exception   <= 1'h0;
            o_irq_exception   <= 1'h0;
            o_irq_wake_source <= {IRQ_COUNT{1'h0}};
        end
        else
        begin
            o_mode            <= state_d;
            o_cpu_halt        <= (state_d != ST_RUN);                                  // [R01]
            o_periph_stop     <= (state_d inside {ST_SW_STBY, ST_OSC_WAIT, ST_HW_STBY}); // [R06]
            o_osc_enable      <= !(state_d inside {ST_SW_STBY, ST_HW_STBY});           // [R06] [R19]
            o_wdt_clock_only  <= (state_d == ST_OSC_WAIT);                             // [R08]
            o_chip_clock_en   <= (state_d inside {ST_RUN, ST_SLEEP, ST_RESET});        // [R12]
            o_port_hiz        <= (state_d inside {ST_SW_STBY, ST_OSC_WAIT}) &
                                 ((state_q == ST_RUN) ? i_port_float_select : hiz_sel_q); // [R07]
            o_chip_reset      <= (state_d == ST_HW_STBY);                              // [R17]
            o_por_reset       <= (state_d == ST_RESET) & (por_active | ~hw_standby_pin_pin_n);  // [R03] [R19]
            o_manual_reset    <= (state_d == ST_RESET) & ~por_active & manual_reset_pin_active;    // [R04]
            o_sleep_dma_block <= (state_d == ST_SLEEP);                                // [R02]
            o_nmi_exception   <= leave_wait & wake_nmi_q;                              // [R09]
            o_irq_exception   <= leave_wait & ~wake_nmi_q;                             // [R13]
            o_irq_wake_source <= leave_wait ? wake_irq_q : {IRQ_COUNT{1'h0}};
        end
    end

    // Per-module stop bits; hardware standby forces them to reset values
    generate
        for (g = 0; g < NMOD; g++)
        begin : g_mstop
            module_stop_gate #(
                .RESET_VAL (MSTOP_RESET[g])
            ) u_gate (
                .i_clk        (i_clk),
                .i_rst_n      (i_rst_n),
                .i_force_reset(state_d == ST_HW_STBY),
                .i_wr         (i_module_stop_wr),
                .i_wdata      (i_module_stop_wdata[g]),
                .i_bus_end    (i_bus_cycle_end),
                .i_access_req (i_module_access_req[g]),
                .o_stop       (o_module_stop[g]),
                .o_grant      (o_module_access_grant[g])
            ); // [R20] [R21] [R22]
        end
    endgenerate

    property p_hw_priority;
        @(posedge i_clk) disable iff (!i_rst_n)
        !hw_standby_pin_pin_n |=> (state_q == ST_HW_STBY) && o_chip_reset;
    endproperty
    a_hw_priority: assert property (p_hw_priority) else $error("standby pin not obeyed"); // [R05]

    property p_sleep_entry;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_RUN) && i_sleep_exec && !i_standby_select && hw_standby_pin_pin_n
            && !por_active && !manual_reset_pin_active
        |=> (state_q == ST_SLEEP) && o_cpu_halt && !o_periph_stop && o_chip_clock_en;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep entry"); // [R01]

    property p_sw_entry;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_RUN) && i_sleep_exec && i_standby_select && hw_standby_pin_pin_n
            && !por_active && !manual_reset_pin_active
        |=> (state_q == ST_SW_STBY) && !o_osc_enable && o_periph_stop;
    endproperty
    a_sw_entry: assert property (p_sw_entry) else $error("bad standby entry"); // [R06]

    property p_sleep_por;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_SLEEP) && hw_standby_pin_pin_n && por_active |=> (state_q == ST_RESET) && o_por_reset;
    endproperty
    a_sleep_por: assert property (p_sleep_por) else $error("sleep not ended by reset"); // [R03]

    property p_sw_por;
        @(posedge i_clk) disable iff (!i_rst_n)
        in_sw_stby && hw_standby_pin_pin_n && por_active |=> o_chip_clock_en && o_osc_enable;
    endproperty
    a_sw_por: assert property (p_sw_por) else $error("reset did not restart clock"); // [R12]

    property p_wake_wdt_only;
        @(posedge i_clk) disable iff (!i_rst_n)
        enter_wait |=> o_wdt_clock_only && !o_chip_clock_en && !o_nmi_exception;
    endproperty
    a_wake_wdt_only: assert property (p_wake_wdt_only) else $error("wake clock reached chip"); // [R08]

    property p_irq_gated;
        @(posedge i_clk) disable iff (!i_rst_n)
        in_sw_stby && !i_irq_wake_enable && !nmi_wake |=> (state_q != ST_OSC_WAIT);
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq woke while disabled"); // [R13]

    property p_wait_length;
        @(posedge i_clk) disable iff (!i_rst_n)
        leave_wait |-> (wait_cnt_q == (WAIT_CNT_W'(WAIT_BASE) << cks_q) - WAIT_CNT_W'(1))
            ##1 (o_nmi_exception ^ o_irq_exception) && o_chip_clock_en;
    endproperty
    a_wait_length: assert property (p_wait_length) else $error("overflow exit mistimed"); // [R09]

    property p_hw_exit;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_HW_STBY) && hw_standby_pin_pin_n |=> (state_q == ST_RESET) && o_osc_enable;
    endproperty
    a_hw_exit: assert property (p_hw_exit) else $error("standby release not to reset"); // [R19]

endmodule : low_power_mode_controller

// *** src/lpm_pkg.sv ***
package lpm_pkg;

    // Operating modes of the power controller
    typedef enum logic [2:0]
    {
        ST_RUN      = 3'b000,
        ST_SLEEP    = 3'b001,
        ST_SW_STBY  = 3'b010,
        ST_OSC_WAIT = 3'b011,
        ST_HW_STBY  = 3'b100,
        ST_RESET    = 3'b101
    } lpm_state_type;

    // Edge encodings of the irq edge select field, two bits per pin
    localparam logic [1:0] IRQ_EDGE_FALL = 2'h1;
    localparam logic [1:0] IRQ_EDGE_RISE = 2'h2;
    localparam logic [1:0] IRQ_EDGE_BOTH = 2'h3;

    // Sense select: 1 means edge sensing, 0 means low level
    localparam logic       IRQ_SENSE_EDGE = 1'h1;

    // Nmi edge select: 0 falling, 1 rising
    localparam logic       NMI_EDGE_RISE = 1'h1;

    // Watchdog base overflow period in cycles, scaled by 2**clock select
    localparam int         WDT_BASE_CYCLES = 256;
    localparam int         WAIT_CNT_W      = 24;

    // Module standby bits: three serial units, multifunction timer,
    // motor timer, compare timer, two converters; all stopped after reset
    localparam int         MSTOP_COUNT = 8;
    localparam logic [7:0] MSTOP_RESET = 8'hFF;

    localparam int         IRQ_COUNT = 4;

endpackage : lpm_pkg

// *** src/module_stop_gate.sv ***
`timescale 1ns/10ps
// One peripheral's stop bit: request taken at bus cycle end, access gate
module module_stop_gate #(
    parameter logic RESET_VAL = 1'h1
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Control
    input  wire logic i_force_reset,
    input  wire logic i_wr,
    input  wire logic i_wdata,
    input  wire logic i_bus_end,
    input  wire logic i_access_req,
    // Status
    output logic      o_stop,
    output logic      o_grant
);

    logic pend_q;
    logic stop_q;
    logic grant_q;
    logic pend_d;
    logic stop_d;

    // A write is held until the bus cycle ends, then applied
    assign pend_d = i_force_reset ? RESET_VAL : (i_wr ? i_wdata : pend_q);
    assign stop_d = i_force_reset ? RESET_VAL : (i_bus_end ? pend_d : stop_q); // [R20] [R17]

    // Registers stay short; reset value puts the module in standby
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pend_q  <= RESET_VAL; // [R21]
            stop_q  <= RESET_VAL;
            grant_q <= 1'h0;
        end
        else
        begin
            pend_q  <= pend_d;
            stop_q  <= stop_d;
            grant_q <= i_access_req & ~stop_d; // [R22]
        end
    end

    assign o_stop  = stop_q;
    assign o_grant = grant_q;

    property p_no_grant_stopped;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_stop |-> !o_grant;
    endproperty
    a_no_grant_stopped: assert property (p_no_grant_stopped) else $error("grant while stopped"); // [R22]

endmodule : module_stop_gate

// *** verification/low_power_mode_controller_tb.sv ***
`timescale 1ns/10ps
module low_power_mode_controller_tb;
    import lpm_pkg::*;
    logic       clk = 1'h0, rst_n = 1'h0, sl = 1'h0, wpor = 1'h0, wmr = 1'h0, ss = 1'h0, pfs = 1'h0;
    logic       nes = 1'h0, iwe = 1'h0, mswr = 1'h0, bce = 1'h0, por_req = 1'h1, mr_req = 1'h0, hs_req = 1'h0;
    logic       nmi_l = 1'h0;
    logic [3:0] irq_l = 4'hF, sense = 4'hF;
    logic [7:0] edg = 8'h55, mswd = 8'h00, mar = 8'h00;
    logic [2:0] cks = 3'h1; // Overflow of 8 cycles outlasts the modelled settling
    logic       por_n, manual_reset_pin_n, hs_n, nmi, halt, pstop, osc, wdto, cken, port_float_select, crst, por, mrst, dblk, nmix, irqx;
    logic [3:0] irq_n, src;
    logic [2:0] mode;
    logic [7:0] mstop, grant;
    int         err_count = 0, comparisons = 0, cycles = 0, n;

    // 100 ns clock
    always #50 clk = ~clk;

    pin_partner i_pin_partner (.i_clk(clk), .i_por_req(por_req), .i_manual_reset_pin_req(mr_req), .i_hs_req(hs_req),
        .i_nmi_lvl(nmi_l), .i_irq_lvl(irq_l), .o_por_n(por_n), .o_manual_reset_pin_n(manual_reset_pin_n), .o_hs_n(hs_n), .o_nmi(nmi),
        .o_irq_n(irq_n));

    // Short overflow base keeps the standby waits brief
    low_power_mode_controller #(.WAIT_BASE(4)) i_low_power_mode_controller (.i_clk(clk), .i_rst_n(rst_n),
        .i_power_on_reset_pin_n(por_n), .i_manual_reset_pin_n(manual_reset_pin_n), .i_hw_standby_pin_n(hs_n),
        .i_nmi_pin(nmi), .i_irq_pin_n(irq_n), .i_sleep_exec(sl), .i_wdt_por(wpor), .i_wdt_manual_reset_pin(wmr),
        .i_standby_select(ss), .i_port_float_select(pfs), .i_nmi_edge_select(nes), .i_irq_wake_enable(iwe),
        .i_irq_sense_select(sense), .i_irq_edge_select(edg), .i_watchdog_clock_select(cks),
        .i_module_stop_wr(mswr), .i_module_stop_wdata(mswd), .i_bus_cycle_end(bce), .i_module_access_req(mar),
        .o_mode(mode), .o_cpu_halt(halt), .o_periph_stop(pstop), .o_osc_enable(osc), .o_wdt_clock_only(wdto),
        .o_chip_clock_en(cken), .o_port_hiz(port_float_select), .o_chip_reset(crst), .o_por_reset(por),
        .o_manual_reset(mrst), .o_sleep_dma_block(dblk), .o_nmi_exception(nmix), .o_irq_exception(irqx),
        .o_irq_wake_source(src), .o_module_stop(mstop), .o_module_access_grant(grant));

    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (e !== g)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task end_sim;
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Bounded wait for a mode, then compare it
    task wait_mode(input logic [2:0] m);
        n = 0;
        while (mode !== m && n < 50)
        begin
            cyc(1);
            n++;
        end
        chk("mode", 8'(m), 8'(mode));
    endtask : wait_mode

    // One-cycle sleep instruction pulse from run
    task enter(input logic s);
        ss = s;
        sl = 1'h1;
        cyc(1);
        sl = 1'h0;
        chk("mode", s ? 8'(ST_SW_STBY) : 8'(ST_SLEEP), 8'(mode));
    endtask : enter

    task t_sleep;
        enter(1'h0);
        chk("halt/periph_stop/dma_block", 8'h05, {5'h0, halt, pstop, dblk});
        mr_req = 1'h1;
        wait_mode(ST_RESET);
        chk("manual_reset", 8'h01, 8'(mrst));
        mr_req = 1'h0;
        wait_mode(ST_RUN);
        enter(1'h0);
        wpor = 1'h1;
        cyc(3);
        chk("mode/por", {4'h0, ST_RESET, 1'h1}, {4'h0, mode, por});
        wpor = 1'h0;
        wait_mode(ST_RUN);
        enter(1'h1);
        por_req = 1'h1;
        wait_mode(ST_RESET);
        chk("chip_clock/osc", 8'h03, {6'h0, cken, osc});
        por_req = 1'h0;
        wait_mode(ST_RUN);
    endtask : t_sleep

    task t_nmi;
        nes = 1'h1;
        pfs = 1'h1;
        enter(1'h1);
        chk("osc/periph_stop/hiz", 8'h03, {5'h0, osc, pstop, port_float_select});
        nmi_l = 1'h1;
        wait_mode(ST_OSC_WAIT);
        chk("wdt_clock_only/chip_clock", 8'h02, {6'h0, wdto, cken});
        n = 0;
        while (nmix !== 1'h1 && n < 100)
        begin
            cyc(1);
            n++;
        end
        chk("overflow wait", 8'h08, 8'(n));
        chk("mode/chip_clock", {4'h0, ST_RUN, 1'h1}, {4'h0, mode, cken});
        nmi_l = 1'h0;
        pfs = 1'h0;
    endtask : t_nmi

    // Each edge encoding on pin 0, with the pin parked at the non-wake level first
    task t_irq;
        enter(1'h1);
        irq_l = 4'hE;
        cyc(6);
        chk("mode", 8'(ST_SW_STBY), 8'(mode));
        irq_l = 4'hF;
        cyc(6);
        iwe = 1'h1;
        for (int e = 1; e < 4; e++)
        begin
            edg[1:0] = 2'(e);
            irq_l[0] = (e != 2);
            cyc(4);
            enter(1'h1);
            irq_l[0] = (e == 2);
            wait_mode(ST_OSC_WAIT);
            n = 0;
            while (irqx !== 1'h1 && n < 100)
            begin
                cyc(1);
                n++;
            end
            chk("irq_exception/source", 8'h11, {3'h0, irqx, src});
        end
        irq_l = 4'hF;
    endtask : t_irq

    task t_mstop;
        // Only the bench writes stop bits, and no module interrupt is pending meanwhile
        mswr = 1'h1;
        mswd = 8'hF0;
        cyc(1);
        mswr = 1'h0;
        chk("module_stop", 8'hFF, mstop);
        bce = 1'h1;
        cyc(1);
        bce = 1'h0;
        chk("module_stop", 8'hF0, mstop);
        mar = 8'hFF;
        cyc(2);
        chk("access_grant", 8'h0F, grant);
        mar = 8'h00;
    endtask : t_mstop

    // Wake priority, RAM enable and boot pins sit outside the block; the bench keeps them untouched
    task t_hw;
        enter(1'h1);
        hs_req = 1'h1;
        wait_mode(ST_HW_STBY);
        chk("chip_reset/module_stop", 8'hFF, crst ? mstop : 8'h00);
        por_req = 1'h1;
        cyc(2);
        hs_req = 1'h0;
        wait_mode(ST_RESET);
        chk("por_reset", 8'h01, 8'(por));
        por_req = 1'h0;
        wait_mode(ST_RUN);
    endtask : t_hw

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            end_sim;
        end
    end

    initial
    begin
        cyc(6);
        rst_n = 1'h1;
        por_req = 1'h0;
        chk("module_stop", 8'hFF, mstop);
        wait_mode(ST_RUN);
        t_sleep;
        t_nmi;
        t_irq;
        t_mstop;
        t_hw;
        end_sim;
    end
endmodule : low_power_mode_controller_tb

// *** verification/pin_partner.sv ***
`timescale 1ns/10ps
// Board-side pin drivers: reset, manual reset, standby and wake pins
module pin_partner #(
    parameter int HOLD = 6
) (
    input  wire logic       i_clk,
    input  wire logic       i_por_req,
    input  wire logic       i_manual_reset_pin_req,
    input  wire logic       i_hs_req,
    input  wire logic       i_nmi_lvl,
    input  wire logic [3:0] i_irq_lvl,
    output logic            o_por_n,
    output logic            o_manual_reset_pin_n,
    output logic            o_hs_n,
    output logic            o_nmi,
    output logic [3:0]      o_irq_n
);
    logic [3:0] hold_q = 4'h0;

    // Reset stays low a while after release is asked, covering oscillator settling
    always_ff @(posedge i_clk)
        hold_q <= i_por_req ? 4'(HOLD) : (hold_q != 4'h0 ? hold_q - 4'h1 : 4'h0);
    assign o_por_n  = !(i_por_req || hold_q != 4'h0);
    // Wake levels come straight from the bench, which keeps entry levels opposite to wake levels
    assign o_manual_reset_pin_n = !i_manual_reset_pin_req;
    assign o_hs_n   = !i_hs_req;
    assign o_nmi    = i_nmi_lvl;
    assign o_irq_n  = i_irq_lvl;
endmodule : pin_partner
